/* src/rdp_cfg.svh */
`ifndef RDP_CFG_SVH
`define RDP_CFG_SVH

// Register byte offsets, one aligned 32-bit word each
`define RDP_OFS_OPT 8'h00
`define RDP_OFS_CAUSE 8'h04
`define RDP_OFS_FRC 8'h08
`define RDP_OFS_DIR 8'h0C
`define RDP_OFS_DAT 8'h10
`define RDP_OFS_PU 8'h14
`define RDP_OFS_DS 8'h18
`define RDP_OFS_SLEW 8'h1C
`define RDP_OFS_STAT 8'h20

// Fields of system_options_reg_one
`define RDP_OPT_RPE 0
`define RDP_OPT_DPE 1
`define RDP_OPT_REMAP 2
`define RDP_OPT_GANG 3
`define RDP_OPT_XCLK 4

// Fields of reset_cause_register
`define RDP_CS_POR 0
`define RDP_CS_PIN 1
`define RDP_CS_INT 2
`define RDP_CS_DBG 3
`define RDP_CS_W 4

// Fields of debug_force_reset_register and status word
`define RDP_FRC_GO 0
`define RDP_ST_BGND 0
`define RDP_ST_XCLK 1
`define RDP_ST_RPE 2

// Pin map of the eight-bit port
`define RDP_PORT_W 8
`define RDP_PIN_RST 5
`define RDP_PIN_DBG 4
`define RDP_TMR_A0 0
`define RDP_TMR_B0 6
`define RDP_GANG_LO 0
`define RDP_GANG_HI 3

// Timing counts in bus clock cycles
`define RDP_PULSE_CYC 66
`define RDP_BIT_CYC 16
`define RDP_CNT_W 7
`define RDP_BIT_W 4

`endif

/* src/rdp_pkg.sv */
`include "rdp_cfg.svh"

package rdp_pkg;

  // Reset sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_DRIVE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RUN = 3'b100
  } rdp_state_t;

  // Everything a pad cell receives
  typedef struct packed {
    logic [`RDP_PORT_W-1:0] out;
    logic [`RDP_PORT_W-1:0] oe_n;
    logic [`RDP_PORT_W-1:0] pu;
    logic [`RDP_PORT_W-1:0] ds;
    logic [`RDP_PORT_W-1:0] slew;
  } rdp_pad_t;

  // Whole state of the block
  typedef struct packed {
    rdp_state_t state;
    logic [`RDP_CNT_W-1:0] cnt;
    logic [`RDP_CS_W-1:0] cause;
    logic smp;
    logic sys_rst;
    logic debug_wire_function_mode;
    logic rpe;
    logic dpe;
    logic remap;
    logic gang;
    logic xclk;
    logic frc;
    logic [`RDP_PORT_W-1:0] dir;
    logic [`RDP_PORT_W-1:0] dat;
    logic [`RDP_PORT_W-1:0] pu;
    logic [`RDP_PORT_W-1:0] ds;
    logic [`RDP_PORT_W-1:0] slew;
    logic [`RDP_PORT_W-1:0] s1;
    logic [`RDP_PORT_W-1:0] s2;
    logic [`RDP_PORT_W-1:0] s3;
    logic [`RDP_PORT_W-1:0] filt;
    rdp_pad_t pad;
    logic [`RDP_BIT_W-1:0] bit_cnt;
    logic bit_stb;
    logic dbg_in;
    logic timer_external_clock_input;
    logic ack;
    logic [31:0] dat_o;
  } rdp_st_t;

endpackage

/* src/rdp_top.sv */
// Chosen here: the Wishbone slave port and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

`include "rdp_cfg.svh"

module rdp_top
  import rdp_pkg::*;
#(
  parameter int PULSE_CYCLES = `RDP_PULSE_CYC
)
(
  // Clock, reset, clock enable
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Wishbone classic slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Port pads
  input wire logic [`RDP_PORT_W-1:0] PAD_I,
  output logic [`RDP_PORT_W-1:0] PAD_O,
  output logic [`RDP_PORT_W-1:0] PAD_OE_N_O,
  output logic [`RDP_PORT_W-1:0] PAD_PU_O,
  output logic [`RDP_PORT_W-1:0] PAD_DS_O,
  output logic [`RDP_PORT_W-1:0] PAD_SLEW_O,
  // Timer unit one channels and external clock
  input wire logic [1:0] TMR_OUT_I,
  input wire logic [1:0] TMR_OE_I,
  output logic TIMER_EXTERNAL_CLOCK_INPUT_O,
  // Serial debug controller
  input wire logic DBG_OUT_I,
  input wire logic DBG_OE_I,
  output logic DBG_IN_O,
  output logic DBG_BIT_STB_O,
  output logic DEBUG_WIRE_FUNCTION_MODE_O,
  // System reset and clock select
  input wire logic INT_RST_REQ_I,
  output logic SYS_RST_O,
  output logic CLK_SEL_EXT_O
);

  // Counter is seven bits wide; the pulse check needs eight cycles
  if (PULSE_CYCLES < 8 || PULSE_CYCLES > 127)
  begin
    $error("PULSE_CYCLES out of range");
  end

  localparam logic [`RDP_CNT_W-1:0] PULSE_LAST =
    `RDP_CNT_W'(PULSE_CYCLES - 1);
  localparam logic [`RDP_BIT_W-1:0] BIT_LAST =
    `RDP_BIT_W'(`RDP_BIT_CYC - 1);

  rdp_st_t s_r; // Registered state
  rdp_st_t s_nxt; // Next state
  logic wb_req; // New bus request this cycle
  logic wr; // Register write strobe
  logic [7:0] wd; // Write data, lane zero
  logic drv; // Reset pin pulled low from the next cycle
  logic go_rst; // Start of a non-power-on reset
  int idx; // Timer pin index

  // Address compare, shared by read and write decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] o);
    return a == o;
  endfunction

  // Read multiplexer over the register map
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (hit(a, `RDP_OFS_OPT))
    begin
      r[`RDP_OPT_RPE] = s_r.rpe;
      r[`RDP_OPT_DPE] = s_r.dpe;
      r[`RDP_OPT_REMAP] = s_r.remap;
      r[`RDP_OPT_GANG] = s_r.gang;
      r[`RDP_OPT_XCLK] = s_r.xclk;
    end
    else if (hit(a, `RDP_OFS_CAUSE))
      r[`RDP_CS_W-1:0] = s_r.cause;
    else if (hit(a, `RDP_OFS_DIR))
      r = s_r.dir;
    else if (hit(a, `RDP_OFS_DAT))
      // Output bits read the latch, input bits the pin
      r = (s_r.dir & s_r.dat) | (~s_r.dir & s_r.filt);
    else if (hit(a, `RDP_OFS_PU))
      r = s_r.pu;
    else if (hit(a, `RDP_OFS_DS))
      r = s_r.ds;
    else if (hit(a, `RDP_OFS_SLEW))
      r = s_r.slew;
    else if (hit(a, `RDP_OFS_STAT))
    begin
      r[`RDP_ST_BGND] = s_r.debug_wire_function_mode;
      r[`RDP_ST_XCLK] = s_r.xclk;
      r[`RDP_ST_RPE] = s_r.rpe;
    end
    return r;
  endfunction

  // Next-state logic for the whole block
  always_comb
  begin
    s_nxt = s_r;
    idx = 0;
    // Three-stage pin sampler; a change counts once stages agree
    s_nxt.s1 = PAD_I;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < `RDP_PORT_W; i++)
    begin
      if (s_r.s2[i] == s_r.s3[i])
        s_nxt.filt[i] = s_r.s3[i];
    end

    // Bus slave: one-cycle answer, ack drops the cycle after
    wb_req = CYC_I & STB_I & ~s_r.ack;
    s_nxt.ack = wb_req;
    if (wb_req)
    begin
      s_nxt.dat_o = '0;
      s_nxt.dat_o[7:0] = rd_mux(ADR_I);
    end
    // Writes are refused while the sequencer holds reset
    wr = wb_req & WE_I & SEL_I[0] & (s_r.state == ST_RUN);
    wd = DAT_I[7:0];
    if (wr && hit(ADR_I, `RDP_OFS_OPT))
    begin
      // Enable can only be set; only power-on clears it
      s_nxt.rpe = s_r.rpe | wd[`RDP_OPT_RPE];
      s_nxt.dpe = wd[`RDP_OPT_DPE];
      s_nxt.remap = wd[`RDP_OPT_REMAP];
      s_nxt.gang = wd[`RDP_OPT_GANG];
      s_nxt.xclk = wd[`RDP_OPT_XCLK];
    end
    if (wr && hit(ADR_I, `RDP_OFS_FRC) && wd[`RDP_FRC_GO])
      s_nxt.frc = 1'b1;
    if (wr && hit(ADR_I, `RDP_OFS_DIR))
      s_nxt.dir = wd;
    if (wr && hit(ADR_I, `RDP_OFS_DAT))
      s_nxt.dat = wd;
    if (wr && hit(ADR_I, `RDP_OFS_PU))
      s_nxt.pu = wd;
    if (wr && hit(ADR_I, `RDP_OFS_DS))
      s_nxt.ds = wd;
    if (wr && hit(ADR_I, `RDP_OFS_SLEW))
      s_nxt.slew = wd;

    // Reset sequencer
    go_rst = 1'b0;
    case (s_r.state)
      ST_RUN:
      begin
        s_nxt.sys_rst = 1'b0;
        // Pin wins over debug force, which wins over internal
        if (s_r.rpe && !s_r.filt[`RDP_PIN_RST])
        begin
          go_rst = 1'b1;
          s_nxt.cause = `RDP_CS_W'(1 << `RDP_CS_PIN);
          s_nxt.smp = 1'b0;
        end
        else if (s_r.frc)
        begin
          go_rst = 1'b1;
          s_nxt.cause = `RDP_CS_W'(1 << `RDP_CS_DBG);
          s_nxt.smp = 1'b1;
        end
        else if (INT_RST_REQ_I)
        begin
          go_rst = 1'b1;
          s_nxt.cause = `RDP_CS_W'(1 << `RDP_CS_INT);
          s_nxt.smp = 1'b0;
        end
      end
      ST_DRIVE:
      begin
        // Hold reset for the pulse length
        if (s_r.cnt == PULSE_LAST)
          s_nxt.state = ST_SAMPLE;
        else
          s_nxt.cnt = s_r.cnt + 1'b1;
      end
      ST_SAMPLE:
      begin
        // Stay in reset while an outside source still pulls low
        if (!s_r.rpe || s_r.filt[`RDP_PIN_RST])
        begin
          s_nxt.state = ST_RUN;
          s_nxt.sys_rst = 1'b0;
          // After power-on or debug force a low pin means background; otherwise run
          s_nxt.debug_wire_function_mode = s_r.smp &
            ~s_r.filt[`RDP_PIN_DBG];
        end
      end
      default:
      begin
        // Lost state: restart as a full reset
        go_rst = 1'b1;
        s_nxt.cause = `RDP_CS_W'(1 << `RDP_CS_INT);
        s_nxt.smp = 1'b0;
      end
    endcase

    // Defaults that every reset restores; reset pin enable kept
    if (go_rst)
    begin
      s_nxt.state = ST_DRIVE;
      s_nxt.cnt = '0;
      s_nxt.sys_rst = 1'b1;
      s_nxt.frc = 1'b0;
      s_nxt.debug_wire_function_mode = 1'b0;
      s_nxt.dpe = 1'b1;
      s_nxt.remap = 1'b0;
      s_nxt.gang = 1'b0;
      s_nxt.xclk = 1'b0;
      s_nxt.dir = '0;
      s_nxt.dat = '0;
      s_nxt.pu = '0;
      s_nxt.ds = '0;
      s_nxt.slew = '0;
    end

    // Pad drive, lowest priority first so later owners win
    drv = (s_r.state == ST_DRIVE) & s_r.rpe &
          ~s_r.cause[`RDP_CS_POR];
    for (int i = 0; i < `RDP_PORT_W; i++)
    begin
      s_nxt.pad.out[i] = s_r.dat[i];
      s_nxt.pad.oe_n[i] = ~s_r.dir[i];
    end
    // Timer channels take their pins by their own enable
    for (int c = 0; c < 2; c++)
    begin
      idx = s_r.remap ? (`RDP_TMR_B0 + c) : (`RDP_TMR_A0 + c);
      if (TMR_OE_I[c])
      begin
        s_nxt.pad.out[idx] = TMR_OUT_I[c];
        s_nxt.pad.oe_n[idx] = 1'b0;
      end
    end
    // Ganged pins copy the lead pin so they share load
    if (s_r.gang)
    begin
      for (int i = `RDP_GANG_LO + 1; i <= `RDP_GANG_HI; i++)
      begin
        s_nxt.pad.out[i] = s_nxt.pad.out[`RDP_GANG_LO];
        s_nxt.pad.oe_n[i] = s_nxt.pad.oe_n[`RDP_GANG_LO];
      end
    end
    // Pullup only makes sense on a pin that is not driving
    for (int i = 0; i < `RDP_PORT_W; i++)
      s_nxt.pad.pu[i] = s_r.pu[i] & s_nxt.pad.oe_n[i];
    s_nxt.pad.ds = s_r.ds;
    s_nxt.pad.slew = s_r.slew;
    // Debug wire owns its pin; input only while in reset
    if (s_r.dpe)
    begin
      // The controller's own drive carries the speedup pulse
      s_nxt.pad.out[`RDP_PIN_DBG] = DBG_OUT_I;
      s_nxt.pad.oe_n[`RDP_PIN_DBG] =
        s_r.sys_rst | ~DBG_OE_I;
      s_nxt.pad.pu[`RDP_PIN_DBG] = 1'b1;
    end
    // Reset function is top priority on its pin, open drain
    if (s_r.rpe)
    begin
      s_nxt.pad.out[`RDP_PIN_RST] = 1'b0;
      s_nxt.pad.oe_n[`RDP_PIN_RST] = ~drv;
      s_nxt.pad.pu[`RDP_PIN_RST] = 1'b1;
    end

    // Inputs handed to the controller and the timer
    s_nxt.dbg_in = s_r.filt[`RDP_PIN_DBG];
    s_nxt.timer_external_clock_input = ~s_r.rpe & s_r.filt[`RDP_PIN_RST];

    // Bit-time strobe for the debug wire
    if (s_r.dpe && !s_r.sys_rst)
    begin
      s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
      s_nxt.bit_stb = (s_r.bit_cnt == BIT_LAST);
    end
    else
    begin
      s_nxt.bit_cnt = '0;
      s_nxt.bit_stb = 1'b0;
    end
  end

  // State register; power-on leaves the pin a plain input
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s_r <= '0;
      s_r.state <= ST_DRIVE;
      s_r.cause <= `RDP_CS_W'(1 << `RDP_CS_POR);
      s_r.smp <= 1'b1;
      s_r.sys_rst <= 1'b1;
      s_r.rpe <= 1'b0;
      s_r.dpe <= 1'b1;
      s_r.pad.oe_n <= '1;
    end
    else if (CE_I)
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign DAT_O = s_r.dat_o;
  assign ACK_O = s_r.ack;
  assign PAD_O = s_r.pad.out;
  assign PAD_OE_N_O = s_r.pad.oe_n;
  assign PAD_PU_O = s_r.pad.pu;
  assign PAD_DS_O = s_r.pad.ds;
  assign PAD_SLEW_O = s_r.pad.slew;
  assign TIMER_EXTERNAL_CLOCK_INPUT_O = s_r.timer_external_clock_input;
  assign DBG_IN_O = s_r.dbg_in;
  assign DBG_BIT_STB_O = s_r.bit_stb;
  assign DEBUG_WIRE_FUNCTION_MODE_O = s_r.debug_wire_function_mode;
  assign SYS_RST_O = s_r.sys_rst;
  assign CLK_SEL_EXT_O = s_r.xclk;

  // Checks; a frozen clock enable stalls counts, so skip it
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I || !CE_I);

  // Follows the parameter, so a shortened pulse is checked too
  localparam int PLS_GAP = PULSE_CYCLES - 8;
  localparam int BIT_T = `RDP_BIT_CYC;

  logic pin_lo; // Reset pin actively pulled low
  assign pin_lo = s_r.rpe & ~s_r.pad.oe_n[`RDP_PIN_RST];

  por_plain_a: assert property (
    s_r.cause[`RDP_CS_POR] && s_r.state == ST_DRIVE |-> !pin_lo)
    else $error("pin driven during power-on reset");

  rpe_set_a: assert property (
    wr && hit(ADR_I, `RDP_OFS_OPT) && wd[`RDP_OPT_RPE]
    |=> s_r.rpe ##1 s_r.pad.pu[`RDP_PIN_RST])
    else $error("reset pin enable not taken");

  rpe_stick_a: assert property (
    s_r.rpe |=> s_r.rpe)
    else $error("reset pin enable lost");

  ext_rst_a: assert property (
    s_r.state == ST_RUN && s_r.rpe && !s_r.filt[`RDP_PIN_RST]
    |=> s_r.sys_rst && s_r.cause[`RDP_CS_PIN])
    else $error("external low did not reset");

  pulse_len_a: assert property (
    $rose(pin_lo) |-> pin_lo [*8] ##PLS_GAP pin_lo ##1 !pin_lo)
    else $error("reset pulse length wrong");

  cause_one_a: assert property (
    s_r.state == ST_SAMPLE |-> $onehot(s_r.cause))
    else $error("reset cause not one-hot");

  mode_run_a: assert property (
    s_r.state == ST_SAMPLE && s_r.filt[`RDP_PIN_DBG] |=> !s_r.debug_wire_function_mode)
    else $error("high mode pin gave background mode");

  dbg_pu_a: assert property (
    s_r.dpe && !s_r.rpe |=> s_r.pad.pu[`RDP_PIN_DBG])
    else $error("debug pullup missing");

  dpe_set_a: assert property (
    s_r.state == ST_SAMPLE |-> s_r.dpe)
    else $error("reset did not set debug enable");

  bit_time_a: assert property (
    s_r.bit_stb && s_r.dpe |-> ##BIT_T (s_r.bit_stb || !s_r.dpe
      || s_r.sys_rst))
    else $error("debug bit time wrong");

  port_dflt_a: assert property (
    s_r.state == ST_DRIVE |-> s_r.dir == '0 && s_r.pu == '0
      && !s_r.xclk)
    else $error("reset defaults not applied");

  tmr_own_a: assert property (
    TMR_OE_I[0] && !s_r.remap && !s_r.gang
    |=> !s_r.pad.oe_n[`RDP_TMR_A0])
    else $error("timer did not take its pin");

  pin_rst_c: cover property (s_r.cause[`RDP_CS_PIN] && pin_lo);
  dbg_bgnd_c: cover property (s_r.debug_wire_function_mode && s_r.cause[`RDP_CS_DBG]);
  remap_c: cover property (s_r.remap
    && !s_r.pad.oe_n[`RDP_TMR_B0]);
  int_rst_c: cover property (s_r.cause[`RDP_CS_INT] && s_r.sys_rst);

endmodule

`default_nettype wire

/* tb/rdp_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none

`include "rdp_cfg.svh"

// Board wiring and debug pod: resolves the level seen on every pad
module rdp_ext_model
  import rdp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Pad drive from the block
  input wire logic [`RDP_PORT_W-1:0] out_i,
  input wire logic [`RDP_PORT_W-1:0] oe_n_i,
  input wire logic [`RDP_PORT_W-1:0] pu_i,
  // Board or pod drive requested by the bench
  input wire logic [`RDP_PORT_W-1:0] ext_en_i,
  input wire logic [`RDP_PORT_W-1:0] ext_val_i,
  // Resolved pad levels
  output logic [`RDP_PORT_W-1:0] lvl_o
);

  logic tog_r = 1'b0; // Floating lines wander, never hold a value
  logic pod_r = 1'b0; // Pod hold state one cycle ago
  logic [1:0] spd_r = 2'h0; // Speedup pulse left on the debug line

  // Pod letting go of the debug line drives it high briefly
  always @(posedge clk_i)
  begin
    tog_r <= ~tog_r;
    pod_r <= ext_en_i[`RDP_PIN_DBG];
    if (pod_r && !ext_en_i[`RDP_PIN_DBG])
      spd_r <= 2'h2;
    else if (spd_r != 2'h0)
      spd_r <= spd_r - 2'h1;
  end

  // Block drive wins, then board or pod, then the debug speedup pulse, then pullup, else floating
  always_comb
  begin
    for (int i = 0; i < `RDP_PORT_W; i++)
    begin
      if (!oe_n_i[i])
        lvl_o[i] = out_i[i];
      else if (ext_en_i[i])
        lvl_o[i] = ext_val_i[i]; // Pin pulled low, pod holds mode
      else if (i == `RDP_PIN_DBG && spd_r != 2'h0)
        lvl_o[i] = 1'b1;
      else if (pu_i[i])
        lvl_o[i] = 1'b1;
      else
        lvl_o[i] = tog_r ^ i[0];
    end
  end

endmodule

`default_nettype wire

/* tb/test_reset_and_debug_pin_control.sv */
`timescale 1ns/1ps
`default_nettype none

`include "rdp_cfg.svh"

module test_reset_and_debug_pin_control
  import rdp_pkg::*;
;
  localparam int PULSE = 8; // Short reset pulse keeps the run brief

  logic CLOCK_I = 1'b0;
  logic RST_I = 1'b1;
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic WE_I = 1'b0;
  logic [7:0] ADR_I = 8'h00;
  logic [31:0] DAT_I = 32'h0;
  logic [31:0] DAT_O;
  logic ACK_O;
  logic [7:0] PAD_I, PAD_O, PAD_OE_N_O, PAD_PU_O, PAD_DS_O, PAD_SLEW_O;
  logic [1:0] TMR_OUT_I = 2'h0;
  logic [1:0] TMR_OE_I = 2'h0;
  logic DBG_BIT_STB_O, DEBUG_WIRE_FUNCTION_MODE_O, SYS_RST_O, CLK_SEL_EXT_O;
  logic INT_RST_REQ_I = 1'b0;
  logic DBG_OUT_I = 1'b0; // Debug controller drive, speedup pulse
  logic DBG_OE_I = 1'b0;
  logic TIMER_EXTERNAL_CLOCK_INPUT_O, DBG_IN_O;
  logic [7:0] ext_en = 8'h00; // Board drives these pins
  logic [7:0] ext_val = 8'h00;
  int miscompares = 0;
  int checked = 0;
  int lowcnt = 0; // Cycles the block pulls the reset pin low
  int n0;
  logic [31:0] rv;

  rdp_top #(.PULSE_CYCLES(PULSE)) dut_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .CE_I(1'b1), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(4'h1), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .PAD_I(PAD_I), .PAD_O(PAD_O), .PAD_OE_N_O(PAD_OE_N_O),
    .PAD_PU_O(PAD_PU_O), .PAD_DS_O(PAD_DS_O), .PAD_SLEW_O(PAD_SLEW_O),
    .TMR_OUT_I(TMR_OUT_I), .TMR_OE_I(TMR_OE_I), .TIMER_EXTERNAL_CLOCK_INPUT_O(TIMER_EXTERNAL_CLOCK_INPUT_O),
    .DBG_OUT_I(DBG_OUT_I), .DBG_OE_I(DBG_OE_I), .DBG_IN_O(DBG_IN_O),
    .DBG_BIT_STB_O(DBG_BIT_STB_O), .DEBUG_WIRE_FUNCTION_MODE_O(DEBUG_WIRE_FUNCTION_MODE_O),
    .INT_RST_REQ_I(INT_RST_REQ_I), .SYS_RST_O(SYS_RST_O),
    .CLK_SEL_EXT_O(CLK_SEL_EXT_O));

  rdp_ext_model ext_u (.clk_i(CLOCK_I), .out_i(PAD_O), .oe_n_i(PAD_OE_N_O),
    .pu_i(PAD_PU_O), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(PAD_I));

  // 40 MHz bus clock
  initial
  begin
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end

  // Count the block's own low drive on the reset pin
  always @(posedge CLOCK_I)
  begin
    if (PAD_OE_N_O[5] === 1'b0 && PAD_O[5] === 1'b0)
      lowcnt++;
  end

  task automatic conclude();
  begin
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd);
    int n;
  begin
    @(posedge CLOCK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= adr;
    DAT_I <= wd;
    n = 0;
    do
    begin
      @(posedge CLOCK_I);
      n++;
    end
    while (ACK_O !== 1'b1 && n < 50);
    rv = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    check("ack", 32'(ACK_O), 32'h1);
  end
  endtask

  task automatic rd(input string what, input logic [7:0] adr,
                    input logic [31:0] exp);
  begin
    wb(1'b0, adr, 32'h0);
    check(what, rv, exp);
  end
  endtask

  // Bounded wait for the system reset level
  task automatic wait_sys(input logic lvl);
    int n;
  begin
    n = 0;
    while (SYS_RST_O !== lvl && n < 300)
    begin
      @(posedge CLOCK_I);
      n++;
    end
    check("sys_rst", 32'(SYS_RST_O), 32'(lvl));
  end
  endtask

  task automatic settle();
  begin
    repeat (4) @(posedge CLOCK_I);
  end
  endtask

  task automatic t_por();
  begin
    check("oe_n", 32'(PAD_OE_N_O), 32'hFF);
    check("pu", 32'(PAD_PU_O), 32'h10);
    check("ext clk", 32'(CLK_SEL_EXT_O), 32'h0);
    check("debug_wire_function", 32'(DEBUG_WIRE_FUNCTION_MODE_O), 32'h0);
    rd("opt", `RDP_OFS_OPT, 32'h02);
    rd("cause", `RDP_OFS_CAUSE, 32'h01);
  end
  endtask

  // Bit strobe spacing of the debug wire
  task automatic t_bit();
    int n;
  begin
    n = 0;
    do @(posedge CLOCK_I); while (DBG_BIT_STB_O !== 1'b1 && ++n < 40);
    n = 0;
    do
    begin
      @(posedge CLOCK_I);
      n++;
    end
    while (DBG_BIT_STB_O !== 1'b1 && n < 40);
    check("bit time", n, 16);
  end
  endtask

  task automatic t_port();
  begin
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    wb(1'b1, `RDP_OFS_OPT, 32'h00);
    wb(1'b1, `RDP_OFS_DIR, 32'h0F);
    wb(1'b1, `RDP_OFS_DAT, 32'h05);
    wb(1'b1, `RDP_OFS_PU, 32'hFF);
    wb(1'b1, `RDP_OFS_DS, 32'hFF);
    wb(1'b1, `RDP_OFS_SLEW, 32'hFF);
    wb(1'b1, 8'h24, 32'hFF);
    settle();
    check("out", 32'(PAD_O[3:0]), 32'h5);
    check("oe_n", 32'(PAD_OE_N_O), 32'hF0);
    check("pu", 32'(PAD_PU_O), 32'hF0);
    check("ds", 32'(PAD_DS_O[3:0]), 32'hF);
    check("slew", 32'(PAD_SLEW_O[3:0]), 32'hF);
    check("timer_external_clock_input", 32'(TIMER_EXTERNAL_CLOCK_INPUT_O), 32'h1);
    check("dbg in", 32'(DBG_IN_O), 32'h0);
    rd("dat", `RDP_OFS_DAT, 32'hA5);
    rd("unmapped", 8'h24, 32'h0);
    // Gang: pins 1..3 follow pin 0
    wb(1'b1, `RDP_OFS_DIR, 32'h01);
    wb(1'b1, `RDP_OFS_DAT, 32'h01);
    wb(1'b1, `RDP_OFS_OPT, 32'h08);
    settle();
    check("gang out", 32'(PAD_O[3:0]), 32'hF);
    check("gang oe", 32'(PAD_OE_N_O[3:0]), 32'h0);
  end
  endtask

  task automatic t_timer();
  begin
    ext_en <= 8'hFC;
    wb(1'b1, `RDP_OFS_OPT, 32'h00);
    wb(1'b1, `RDP_OFS_DIR, 32'h00);
    TMR_OE_I <= 2'h3;
    TMR_OUT_I <= 2'h1;
    settle();
    check("tmr oe", 32'(PAD_OE_N_O), 32'hFC);
    check("tmr out", 32'(PAD_O[1:0]), 32'h1);
    rd("tmr dat", `RDP_OFS_DAT, 32'hA1);
    ext_en <= 8'h3F; // Pins 0 and 1 held low once the timer leaves
    wb(1'b1, `RDP_OFS_OPT, 32'h04);
    settle();
    check("remap oe", 32'(PAD_OE_N_O), 32'h3F);
    check("remap out", 32'(PAD_O[7:6]), 32'h1);
    rd("remap dat", `RDP_OFS_DAT, 32'h60);
    TMR_OE_I <= 2'h0;
    ext_en <= 8'h00;
  end
  endtask

  task automatic t_int();
  begin
    wb(1'b1, `RDP_OFS_OPT, 32'h10);
    settle();
    check("xclk", 32'(CLK_SEL_EXT_O), 32'h1);
    n0 = lowcnt;
    INT_RST_REQ_I <= 1'b1;
    @(posedge CLOCK_I);
    INT_RST_REQ_I <= 1'b0;
    wait_sys(1'b1);
    wait_sys(1'b0);
    check("no pulse", lowcnt - n0, 0);
    check("xclk rst", 32'(CLK_SEL_EXT_O), 32'h0);
    rd("cause", `RDP_OFS_CAUSE, 32'h04);
    rd("opt", `RDP_OFS_OPT, 32'h02);
  end
  endtask

  task automatic t_pin();
  begin
    wb(1'b1, `RDP_OFS_OPT, 32'h01);
    settle();
    check("rst pu", 32'(PAD_PU_O[5]), 32'h1);
    check("rst oe", 32'(PAD_OE_N_O[5]), 32'h1);
    n0 = lowcnt;
    ext_val <= 8'h00;
    ext_en <= 8'h20;
    wait_sys(1'b1);
    ext_en <= 8'h00;
    wait_sys(1'b0);
    check("pulse", lowcnt - n0, PULSE);
    check("debug_wire_function", 32'(DEBUG_WIRE_FUNCTION_MODE_O), 32'h0);
    rd("cause", `RDP_OFS_CAUSE, 32'h02);
    rd("opt", `RDP_OFS_OPT, 32'h03);
  end
  endtask

  task automatic t_force();
  begin
    n0 = lowcnt;
    ext_en <= 8'h10;
    wb(1'b1, `RDP_OFS_FRC, 32'h01);
    wait_sys(1'b1);
    wait_sys(1'b0);
    ext_en <= 8'h00;
    check("pulse", lowcnt - n0, PULSE);
    check("debug_wire_function", 32'(DEBUG_WIRE_FUNCTION_MODE_O), 32'h1);
    rd("cause", `RDP_OFS_CAUSE, 32'h08);
    rd("stat", `RDP_OFS_STAT, 32'h05);
    settle();
    check("dbg pu", 32'(PAD_PU_O[4]), 32'h1);
    DBG_OUT_I <= 1'b1;
    DBG_OE_I <= 1'b1;
    settle();
    check("dbg drive", 32'({PAD_OE_N_O[4], PAD_O[4]}), 32'h1);
    DBG_OE_I <= 1'b0;
    DBG_OUT_I <= 1'b0;
  end
  endtask

  // Power-on again clears the sticky reset pin enable
  task automatic t_repor();
  begin
    RST_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    wait_sys(1'b0);
    check("debug_wire_function por", 32'(DEBUG_WIRE_FUNCTION_MODE_O), 32'h0);
    rd("opt por", `RDP_OFS_OPT, 32'h02);
    rd("cause por", `RDP_OFS_CAUSE, 32'h01);
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    wait_sys(1'b0);
    t_por();
    t_bit();
    t_port();
    t_timer();
    t_int();
    t_pin();
    t_force();
    t_repor();
    conclude();
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #(25 * 20000);
    miscompares++;
    conclude();
  end

endmodule

`default_nettype wire
